// file: cbd_defines.svh
// bit positions, codes and reset values of the command byte decoder
`ifndef CBD_DEFINES_SVH
`define CBD_DEFINES_SVH

`define CBD_CMD_BIT      7
`define CBD_TYPE_HI      6
`define CBD_TYPE_LO      5
`define CBD_FIELD_HI     4
`define CBD_FIELD_LO     0

`define CBD_TYPE_REPEAT  2'h0
`define CBD_TYPE_AUTO    2'h1
`define CBD_TYPE_RSVD    2'h2
`define CBD_TYPE_SPECIAL 2'h3

`define CBD_SF_NOP       5'h00
`define CBD_SF_PROX_CLR  5'h05
`define CBD_SF_ALS_CLR   5'h06
`define CBD_SF_BOTH_CLR  5'h07

`define CBD_ADDR_RESET   5'h00
`define CBD_ADDR_STEP    5'h01

`endif

// file: cbd_pkg.sv
// types shared by the command byte decoder and its byte-level bus front end
`default_nettype none

package cbd_pkg;

	// framing events from the serial slave after its address phase
	typedef struct packed {
		logic start;   // address matched, transaction begins
		logic is_read; // direction of the transaction that begins
		logic stop;    // transaction over
	} cbd_xfer_t;

	// one byte written by the host
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} cbd_byte_t;

	// one data write towards the register file
	typedef struct packed {
		logic       we;
		logic [4:0] addr;
		logic [7:0] data;
	} cbd_reg_wr_t;

	// where the decoder stands inside a transaction
	typedef enum logic [1:0] {
		CBD_IDLE  = 2'b00,
		CBD_FIRST = 2'b01,
		CBD_DATA  = 2'b11
	} cbd_state_t;

endpackage

`default_nettype wire

// file: cbd_command_decoder.sv
// command byte decoder: held register address, transfer type and interrupt clears
// How it works
// - keep the register address set by the latest address-carrying command
// - type 00 repeats, 01 auto-increments, 11 special; 10 is reserved
// - repeated-byte type keeps the held address for every data access
// - auto-increment type steps the held address after each data byte
// - low five bits are an address, or a special code for type 11
// - special codes: 0 nothing, 5 proximity clear, 6 ambient clear, 7 both
// - interrupt clears are single pulses, nothing stored for software
// - first written byte of a transaction is the command if its top bit is set, later bytes data
// - a read with no command first uses the held address
// - a written byte with top bit clear is data at the held address
`timescale 1ns/1ps
`default_nettype none
`include "cbd_defines.svh"

module cbd_command_decoder (
	input  wire logic               CLK,
	input  wire logic               RST,
	input  wire cbd_pkg::cbd_xfer_t XFER,
	input  wire cbd_pkg::cbd_byte_t WR_BYTE,
	input  wire logic               RD_DONE,
	output logic [4:0]              REG_ADDR,
	output logic                    AUTO_INC,
	output cbd_pkg::cbd_reg_wr_t    REG_WR,
	output logic                    PROX_INT_CLR,
	output logic                    ALS_INT_CLR
);
	import cbd_pkg::*;

	// ************************************************************
	// decoding helpers
	// ************************************************************

	// type field of a byte
	function automatic logic [1:0] type_of(input logic [7:0] b);
		type_of = b[`CBD_TYPE_HI:`CBD_TYPE_LO];
	endfunction

	// low field of a byte: address or special code
	function automatic logic [4:0] field_of(input logic [7:0] b);
		field_of = b[`CBD_FIELD_HI:`CBD_FIELD_LO];
	endfunction

	cbd_state_t state;
	logic       is_cmd;
	logic       addr_cmd;
	logic       special_cmd;
	logic       data_wr;
	logic       step;
	logic [4:0] code;
	logic [1:0] ctype;

	// ************************************************************
	// byte classification
	// ************************************************************

	// only the first written byte can be a command; later ones are data
	assign ctype       = type_of(WR_BYTE.data);
	assign code        = field_of(WR_BYTE.data);
	assign is_cmd      = WR_BYTE.valid && state == CBD_FIRST && WR_BYTE.data[`CBD_CMD_BIT];
	// reserved type 10 is dropped so a stray code cannot move the address
	assign addr_cmd    = is_cmd && (ctype == `CBD_TYPE_REPEAT || ctype == `CBD_TYPE_AUTO);
	assign special_cmd = is_cmd && ctype == `CBD_TYPE_SPECIAL;
	assign data_wr     = WR_BYTE.valid && state != CBD_IDLE && !is_cmd;
	// bytes outside a transaction are ignored
	assign step        = AUTO_INC && (data_wr || (RD_DONE && state != CBD_IDLE));

	// ************************************************************
	// transaction framing
	// ************************************************************

	// a read starts straight in data, so it never sees a command
	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= CBD_IDLE;
		end else if (XFER.stop) begin
			state <= CBD_IDLE;
		end else if (XFER.start) begin
			state <= XFER.is_read ? CBD_DATA : CBD_FIRST;
		end else if (WR_BYTE.valid && state == CBD_FIRST) begin
			state <= CBD_DATA;
		end
	end

	// ************************************************************
	// held address and transfer type
	// ************************************************************

	// special commands leave the held address untouched
	always_ff @(posedge CLK) begin
		if (RST) begin
			REG_ADDR <= `CBD_ADDR_RESET;
		end else if (addr_cmd) begin
			REG_ADDR <= code;
		end else if (step) begin
			REG_ADDR <= REG_ADDR + `CBD_ADDR_STEP; // wraps within five bits
		end
	end

	// the type sticks until the next address-carrying command
	always_ff @(posedge CLK) begin
		if (RST) begin
			AUTO_INC <= 1'b0;
		end else if (addr_cmd) begin
			AUTO_INC <= (ctype == `CBD_TYPE_AUTO);
		end
	end

	// ************************************************************
	// data write towards the register file
	// ************************************************************

	// address is the held one before any step of this byte
	always_ff @(posedge CLK) begin
		if (RST) begin
			REG_WR <= '0;
		end else begin
			REG_WR.we <= data_wr;
			if (data_wr) begin
				REG_WR.addr <= REG_ADDR;
				REG_WR.data <= WR_BYTE.data;
			end
		end
	end

	// ************************************************************
	// interrupt clear strobes
	// ************************************************************

	// one-cycle pulses: the interrupt logic drops its pending flag itself
	always_ff @(posedge CLK) begin
		if (RST) begin
			PROX_INT_CLR <= 1'b0;
			ALS_INT_CLR  <= 1'b0;
		end else begin
			PROX_INT_CLR <= special_cmd && (code == `CBD_SF_PROX_CLR || code == `CBD_SF_BOTH_CLR);
			ALS_INT_CLR  <= special_cmd && (code == `CBD_SF_ALS_CLR || code == `CBD_SF_BOTH_CLR);
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************

	sequence s_addr_cmd;
		addr_cmd;
	endsequence

	sequence s_special;
		special_cmd && code == `CBD_SF_BOTH_CLR;
	endsequence

	property p_addr_load;
		@(posedge CLK) disable iff (RST) s_addr_cmd |=> REG_ADDR == $past(code);
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("command address not loaded");

	property p_repeat_hold;
		@(posedge CLK) disable iff (RST) (!AUTO_INC && !addr_cmd) |=> REG_ADDR == $past(REG_ADDR);
	endproperty
	a_repeat_hold: assert property (p_repeat_hold) else $error("address moved in repeat mode");

	property p_auto_step;
		@(posedge CLK) disable iff (RST) (AUTO_INC && RD_DONE && state == CBD_DATA)
			|=> REG_ADDR == $past(REG_ADDR) + `CBD_ADDR_STEP;
	endproperty
	a_auto_step: assert property (p_auto_step) else $error("read did not step address");

	property p_write_step;
		@(posedge CLK) disable iff (RST) (AUTO_INC && data_wr) |=> REG_WR.we && REG_ADDR == REG_WR.addr + `CBD_ADDR_STEP;
	endproperty
	a_write_step: assert property (p_write_step) else $error("write did not step address");

	property p_special_keeps;
		@(posedge CLK) disable iff (RST) special_cmd |=> REG_ADDR == $past(REG_ADDR) && AUTO_INC == $past(AUTO_INC);
	endproperty
	a_special_keeps: assert property (p_special_keeps) else $error("special command changed address");

	property p_both_clear;
		@(posedge CLK) disable iff (RST) s_special |=> PROX_INT_CLR && ALS_INT_CLR ##1 !PROX_INT_CLR && !ALS_INT_CLR;
	endproperty
	a_both_clear: assert property (p_both_clear) else $error("clear strobes wrong");

	property p_clear_cause;
		@(posedge CLK) disable iff (RST) (PROX_INT_CLR || ALS_INT_CLR) |-> $past(special_cmd);
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("clear without special command");

	property p_data_write;
		@(posedge CLK) disable iff (RST) (WR_BYTE.valid && state == CBD_DATA)
			|=> REG_WR.we && REG_WR.data == $past(WR_BYTE.data) && REG_WR.addr == $past(REG_ADDR);
	endproperty
	a_data_write: assert property (p_data_write) else $error("data byte not written");

	property p_read_no_cmd;
		@(posedge CLK) disable iff (RST) (XFER.start && XFER.is_read && !XFER.stop) |=> state == CBD_DATA;
	endproperty
	a_read_no_cmd: assert property (p_read_no_cmd) else $error("read expects a command");

	property p_first_cmd;
		@(posedge CLK) disable iff (RST) is_cmd |=> !REG_WR.we;
	endproperty
	a_first_cmd: assert property (p_first_cmd) else $error("command byte written as data");

	// a reserved type must leave address, type and strobes as they were
	property p_reserved_type;
		@(posedge CLK) disable iff (RST) (is_cmd && ctype == `CBD_TYPE_RSVD)
			|=> REG_ADDR == $past(REG_ADDR) && AUTO_INC == $past(AUTO_INC) && !PROX_INT_CLR && !ALS_INT_CLR;
	endproperty
	a_reserved_type: assert property (p_reserved_type) else $error("reserved type acted");

	// clears are single pulses; a second command needs a new transaction anyway
	property p_clear_once;
		@(posedge CLK) disable iff (RST) (PROX_INT_CLR || ALS_INT_CLR) |=> !PROX_INT_CLR && !ALS_INT_CLR;
	endproperty
	a_clear_once: assert property (p_clear_once) else $error("clear strobe held");

	// a byte with no open transaction changes nothing
	property p_idle_byte;
		@(posedge CLK) disable iff (RST) (WR_BYTE.valid && state == CBD_IDLE)
			|=> !REG_WR.we && REG_ADDR == $past(REG_ADDR) && !PROX_INT_CLR && !ALS_INT_CLR;
	endproperty
	a_idle_byte: assert property (p_idle_byte) else $error("byte outside transaction acted");

endmodule

`default_nettype wire

// file: cbd_host_model.sv
// host-side model: framing pulses, written bytes and read strobes
`timescale 1ns/1ps
`default_nettype none
module cbd_host_model (
	input  wire logic              CLK,
	output var cbd_pkg::cbd_xfer_t xfer,
	output var cbd_pkg::cbd_byte_t wr_byte,
	output var logic               rd_done
);
	import cbd_pkg::*;
	// idle from time zero so nothing is taken while reset is held
	initial begin
		xfer = '0;
		wr_byte = '0;
		rd_done = 1'b0;
	end
	// one-cycle pulse set after an edge, cleared after the next; the idle gap keeps strobes apart
	task automatic act(input cbd_xfer_t x, input cbd_byte_t b, input logic r);
		@(posedge CLK);
		#1;
		xfer = x;
		wr_byte = b;
		rd_done = r;
		@(posedge CLK);
		#1;
		xfer = '0;
		wr_byte = '0;
		rd_done = 1'b0;
	endtask
	// command bytes carry the top bit; reserved types or codes only where a test wants refusal
	task automatic cmd(input logic [1:0] ty, input logic [4:0] f);
		act('0, '{1'b1, {1'b1, ty, f}}, 1'b0);
	endtask
	// close, then open, so the next written byte is the first of a transaction
	task automatic open(input logic rd);
		act('{1'b0, 1'b0, 1'b1}, '0, 1'b0);
		act('{1'b1, rd, 1'b0}, '0, 1'b0);
	endtask
endmodule
`default_nettype wire

// file: cbd_command_decoder_tb_top.sv
// testbench of the command byte decoder, driven through the host model
`timescale 1ns/1ps
`default_nettype none
module cbd_command_decoder_tb_top;
	import cbd_pkg::*;
	logic        clk;
	logic        rst;
	cbd_xfer_t   xfer;
	cbd_byte_t   wr_byte;
	logic        rd_done;
	logic [4:0]  reg_addr;
	logic        auto_inc;
	cbd_reg_wr_t reg_wr;
	logic        prox_clr;
	logic        als_clr;
	int          n_mismatch = 0;
	int          checks = 0;
	logic [4:0]  codes [6] = '{5'h00, 5'h05, 5'h06, 5'h07, 5'h05, 5'h03};
	cbd_command_decoder u_cbd_command_decoder (.CLK(clk), .RST(rst), .XFER(xfer), .WR_BYTE(wr_byte),
		.RD_DONE(rd_done), .REG_ADDR(reg_addr), .AUTO_INC(auto_inc), .REG_WR(reg_wr),
		.PROX_INT_CLR(prox_clr), .ALS_INT_CLR(als_clr));
	cbd_host_model u_cbd_host_model (.CLK(clk), .xfer(xfer), .wr_byte(wr_byte), .rd_done(rd_done));
	// 4 ns clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// byte-wide compare; narrower values are zero-extended by the caller
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one data byte: expect a write at a, then held address h
	task automatic wdat(input logic [7:0] d, input logic [4:0] a, input logic [4:0] h);
		u_cbd_host_model.act('0, '{1'b1, d}, 1'b0);
		chk("we", 8'h01, {7'h00, reg_wr.we});
		chk("wr addr", {3'h0, a}, {3'h0, reg_wr.addr});
		chk("wr data", d, reg_wr.data);
		chk("held addr", {3'h0, h}, {3'h0, reg_addr});
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// watchdog, far beyond the roughly 110 cycles the tests need
	initial begin
		#20000;
		n_mismatch++;
		test_done();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("reset addr", 8'h00, {3'h0, reg_addr}); // reset state
		u_cbd_host_model.cmd(2'h1, 5'h09);
		chk("closed addr", 8'h00, {3'h0, reg_addr}); // byte outside a transaction
		$display("test reset done");
		u_cbd_host_model.open(1'b0);
		u_cbd_host_model.cmd(2'h1, 5'h01);
		chk("auto", 8'h01, {7'h00, auto_inc}); // auto type held
		wdat(8'hAA, 5'h01, 5'h02); // write steps
		wdat(8'h9F, 5'h02, 5'h03); // top-bit byte later is data
		$display("test auto write done");
		u_cbd_host_model.open(1'b0);
		u_cbd_host_model.cmd(2'h0, 5'h1E);
		wdat(8'h11, 5'h1E, 5'h1E); // repeat keeps address
		wdat(8'h22, 5'h1E, 5'h1E); // second repeat
		u_cbd_host_model.open(1'b1);
		u_cbd_host_model.act('0, '0, 1'b1);
		chk("rd repeat", 8'h1E, {3'h0, reg_addr}); // read with no command
		u_cbd_host_model.open(1'b0);
		wdat(8'h33, 5'h1E, 5'h1E); // first byte data
		$display("test repeat done");
		u_cbd_host_model.open(1'b0);
		u_cbd_host_model.cmd(2'h1, 5'h1F);
		u_cbd_host_model.open(1'b1);
		u_cbd_host_model.act('0, '0, 1'b1);
		chk("rd wrap", 8'h00, {3'h0, reg_addr}); // read steps and wraps
		u_cbd_host_model.act('0, '0, 1'b1);
		chk("rd step", 8'h01, {3'h0, reg_addr}); // next read step
		$display("test auto read done");
		// all special codes, then reserved type 10 and a reserved code: pulses only, address kept
		for (int i = 0; i < 6; i++) begin
			u_cbd_host_model.open(1'b0);
			u_cbd_host_model.cmd(i == 4 ? 2'h2 : 2'h3, codes[i]);
			chk("prox clr", {7'h00, i == 1 || i == 3}, {7'h00, prox_clr}); // clear kind
			chk("als clr", {7'h00, i == 2 || i == 3}, {7'h00, als_clr}); // clear kind
			chk("sf addr", 8'h01, {3'h0, reg_addr}); // code not an address
			@(posedge clk);
			#1;
			chk("clr gone", 8'h00, {6'h00, prox_clr, als_clr}); // nothing stored
		end
		$display("test special done");
		u_cbd_host_model.act('{1'b1, 1'b1, 1'b1}, '0, 1'b0);
		u_cbd_host_model.act('0, '0, 1'b1);
		chk("idle rd", 8'h01, {3'h0, reg_addr}); // stop beats start, read outside ignored
		@(posedge clk);
		#1;
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		chk("rst addr", 8'h00, {3'h0, reg_addr}); // mid-run reset
		chk("rst auto", 8'h00, {7'h00, auto_inc}); // type back to repeat
		u_cbd_host_model.open(1'b0);
		u_cbd_host_model.cmd(2'h1, 5'h1F);
		wdat(8'h44, 5'h1F, 5'h00); // write steps and wraps
		$display("test mid-run reset done");
		test_done();
	end
endmodule
`default_nettype wire
